// ### src/spimsb_port.sv
// byte wide master/slave serial port: control, master engine, pins
`timescale 1ns/10ps
`include "spimsb_regs.svh"

module spimsb_port
	import spimsb_pkg::*;
(
	input  wire logic         sys_clk_i,
	input  wire logic         resetn_i,
	input  wire logic         sck_i,
	input  wire logic         mosi_i,
	input  wire logic         miso_i,
	input  wire logic         ss_n_i,
	input  wire logic         dir_mosi_i,
	input  wire logic         dir_miso_i,
	input  wire logic         dir_sck_i,
	input  wire logic         dir_ss_i,
	input  wire logic         ctrl_wr_i,
	input  wire spimsb_byte_t ctrl_wdata_i,
	input  wire logic         data_wr_i,
	input  wire spimsb_byte_t data_wdata_i,
	input  wire logic         flag_clr_i,
	output logic              mosi_o,
	output logic              mosi_oe_o,
	output logic              sck_o,
	output logic              sck_oe_o,
	output logic              miso_o,
	output logic              miso_oe_o,
	output logic              override_o,
	output spimsb_byte_t      ctrl_o,
	output spimsb_byte_t      rx_data_o,
	output logic              flag_o,
	output logic              wcol_o,
	output logic              busy_o,
	output logic              irq_o
);

	spimsb_byte_t      serial_port_control_q;
	spimsb_byte_t      serial_port_data_q;
	spimsb_byte_t      rx_q;
	spimsb_byte_t      sh_q;
	spimsb_byte_t      slv_rx;
	spimsb_mst_state_t state_q;
	logic [7:0]        div_q;
	logic [2:0]        bit_q;
	logic [2:0]        sync1_q;
	logic [2:0]        sync2_q;
	logic              tgl_seen_q;
	logic [1:0]        rise_dly_q;
	logic [1:0]        end_dly_q;
	logic              ss_seen_q;
	spimsb_byte_t      rsh_q;
	logic              sck_q;
	logic              transfer_done_flag_q;
	logic              wcol_q;
	logic              slv_busy_q;
	logic              slv_tgl;
	logic              slv_miso;
	logic              link_rst_n;
	logic              serial_port_enable_bit;
	logic              transfer_irq_enable;
	logic              master_select_bit;
	logic              lsb_first;
	logic              ss_n_s;
	logic              miso_s;
	logic              tgl_s;
	logic              half_done;
	logic              mst_rise;
	logic              mst_last;
	logic              mst_done;
	logic              slv_done;
	logic              mode_fault;
	logic              busy;
	logic              wr_ok;
	logic              wr_col;
	logic [3:0]        edge_cnt_q;

	// terminal half period count for the selected rate
	function automatic logic [7:0] half_term(input logic       dbl,
	                                         input logic [1:0] rate);
		logic [7:0] t;
		t = `SPIMSB_HALF_DIV4;
		case ({dbl, rate})
			3'b000:  t = `SPIMSB_HALF_DIV4;
			3'b001:  t = `SPIMSB_HALF_DIV16;
			3'b010:  t = `SPIMSB_HALF_DIV64;
			3'b011:  t = `SPIMSB_HALF_DIV128;
			3'b100:  t = `SPIMSB_HALF_DIV2;
			3'b101:  t = `SPIMSB_HALF_DIV8;
			3'b110:  t = `SPIMSB_HALF_DIV32;
			3'b111:  t = `SPIMSB_HALF_DIV64;
			default: t = `SPIMSB_HALF_DIV4;
		endcase
		return t;
	endfunction

	// control fields
	assign serial_port_enable_bit = serial_port_control_q[`SPIMSB_CTRL_EN];
	assign transfer_irq_enable    = serial_port_control_q[`SPIMSB_CTRL_IE];
	assign master_select_bit      = serial_port_control_q[`SPIMSB_CTRL_MASTER_SELECT_BIT];
	assign lsb_first              = serial_port_control_q[`SPIMSB_CTRL_LSB];

	// two stage synchronisers: select pin, miso pin, slave done toggle
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1_q <= 3'b001;
			sync2_q <= 3'b001;
		end else begin
			sync1_q <= {slv_tgl, miso_i, ss_n_i};
			sync2_q <= sync1_q;
		end
	end
	assign ss_n_s = sync2_q[0];
	assign miso_s = sync2_q[1];
	assign tgl_s  = sync2_q[2];

	// slave byte completion arrives as a toggle; select level kept too,
	// idle high after reset so no false select edge follows it
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tgl_seen_q <= 1'b0;
			ss_seen_q  <= 1'b1;
		end else begin
			tgl_seen_q <= tgl_s;
			ss_seen_q  <= ss_n_s;
		end
	end
	assign slv_done = (tgl_s ^ tgl_seen_q) && serial_port_enable_bit
	                  && !master_select_bit;

	// another master pulls our select input low while we are master
	assign mode_fault = serial_port_enable_bit && master_select_bit
	                    && !dir_ss_i && !ss_n_s;

	assign half_done = (div_q == half_term(
		serial_port_control_q[`SPIMSB_CTRL_DBL],
		serial_port_control_q[`SPIMSB_CTRL_RATE_HI:`SPIMSB_CTRL_RATE_LO]));
	assign mst_rise  = (state_q == MST_LEAD) && half_done && !mode_fault;
	assign mst_last  = (state_q == MST_TRAIL) && half_done
	                   && (bit_q == `SPIMSB_LAST_BIT) && !mode_fault;
	// the byte counts as done once its last miso bit is through
	assign mst_done  = end_dly_q[1];

	// busy covers a master byte or a slave frame that has been armed
	assign busy   = (state_q != MST_IDLE) || (end_dly_q != 2'b00)
	                || slv_busy_q;
	assign wr_ok  = data_wr_i && serial_port_enable_bit && !busy;
	assign wr_col = data_wr_i && serial_port_enable_bit && busy;

	// control byte; a mode fault knocks the master bit down
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			serial_port_control_q <= `SPIMSB_CTRL_RST;
		end else if (mode_fault) begin
			serial_port_control_q[`SPIMSB_CTRL_MASTER_SELECT_BIT] <= 1'b0;
		end else if (ctrl_wr_i) begin
			serial_port_control_q <= ctrl_wdata_i;
		end
	end

	// transmit byte; refused writes leave the byte in flight untouched
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			serial_port_data_q <= `SPIMSB_DATA_RST;
		end else if (wr_ok) begin
			serial_port_data_q <= data_wdata_i;
		end
	end

	// slave frame armed from select fall or a write inside the frame
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			slv_busy_q <= 1'b0;
		end else if (!serial_port_enable_bit || master_select_bit || ss_n_s) begin
			slv_busy_q <= 1'b0;
		end else if (slv_done) begin
			slv_busy_q <= 1'b0;
		end else if (!ss_n_s && ss_seen_q) begin
			slv_busy_q <= 1'b1;
		end else if (wr_ok) begin
			slv_busy_q <= 1'b1;
		end
	end

	// master engine: lead phase holds clock low, trail phase holds it high
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= MST_IDLE;
			div_q   <= 8'h00;
			bit_q   <= 3'h0;
			sck_q   <= 1'b0;
		end else if (!serial_port_enable_bit || !master_select_bit
		             || mode_fault) begin
			state_q <= MST_IDLE;
			div_q   <= 8'h00;
			bit_q   <= 3'h0;
			sck_q   <= 1'b0;
		end else begin
			case (state_q)
				MST_IDLE: begin
					div_q <= 8'h00;
					bit_q <= 3'h0;
					sck_q <= 1'b0;
					if (wr_ok) begin
						state_q <= MST_LEAD;
					end
				end
				MST_LEAD: begin
					div_q <= half_done ? 8'h00 : div_q + 8'h01;
					if (half_done) begin
						sck_q   <= 1'b1;
						state_q <= MST_TRAIL;
					end
				end
				MST_TRAIL: begin
					div_q <= half_done ? 8'h00 : div_q + 8'h01;
					if (half_done) begin
						sck_q <= 1'b0;
						bit_q <= bit_q + 3'h1;
						if (bit_q == `SPIMSB_LAST_BIT) begin
							state_q <= MST_IDLE;
						end else begin
							state_q <= MST_LEAD;
						end
					end
				end
				default: begin
					state_q <= MST_IDLE;
				end
			endcase
		end
	end

	// transmit shifter: loaded by the write, next bit at each falling edge
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sh_q <= `SPIMSB_DATA_RST;
		end else if (state_q == MST_IDLE) begin
			if (wr_ok && master_select_bit) begin
				sh_q <= data_wdata_i;
			end
		end else if (state_q == MST_TRAIL && half_done) begin
			sh_q <= lsb_first ? {1'b0, sh_q[7:1]}
			                  : {sh_q[6:0], 1'b0};
		end
	end

	// the miso synchroniser is two clocks late, so rising edges and the
	// byte end are delayed by two; else double speed reads stale bits
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rise_dly_q <= 2'b00;
			end_dly_q  <= 2'b00;
		end else if (!serial_port_enable_bit || !master_select_bit
		             || mode_fault) begin
			rise_dly_q <= 2'b00;
			end_dly_q  <= 2'b00;
		end else begin
			rise_dly_q <= {rise_dly_q[0], mst_rise};
			end_dly_q  <= {end_dly_q[0], mst_last};
		end
	end

	// receive shifter takes the pin as it stood at each rising edge
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rsh_q <= `SPIMSB_DATA_RST;
		end else if (rise_dly_q[1]) begin
			rsh_q <= lsb_first ? {miso_s, rsh_q[7:1]}
			                   : {rsh_q[6:0], miso_s};
		end
	end

	// receive buffer, overwritten by each completed byte
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_q <= `SPIMSB_DATA_RST;
		end else if (mst_done) begin
			rx_q <= rsh_q;
		end else if (slv_done) begin
			rx_q <= slv_rx;
		end
	end

	// done flag: setting wins over a clear in the same cycle
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			transfer_done_flag_q <= 1'b0;
		end else if (mst_done || slv_done || mode_fault) begin
			transfer_done_flag_q <= 1'b1;
		end else if (flag_clr_i) begin
			transfer_done_flag_q <= 1'b0;
		end
	end

	// collision flag, same set-over-clear priority
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wcol_q <= 1'b0;
		end else if (wr_col) begin
			wcol_q <= 1'b1;
		end else if (flag_clr_i) begin
			wcol_q <= 1'b0;
		end
	end

	// link side is held in reset unless an enabled slave is selected
	assign link_rst_n = resetn_i && serial_port_enable_bit
	                    && !master_select_bit && !ss_n_i;

	spimsb_slave u_slave (
		.sck_i        (sck_i),
		.link_rst_n_i (link_rst_n),
		.resetn_i     (resetn_i),
		.mosi_i       (mosi_i),
		.tx_byte_i    (serial_port_data_q),
		.lsb_first_i  (lsb_first),
		.miso_o       (slv_miso),
		.done_tgl_o   (slv_tgl),
		.rx_byte_o    (slv_rx)
	);

	// pin directions by mode; no select output exists at all
	always_comb begin
		mosi_oe_o  = 1'b0;
		sck_oe_o   = 1'b0;
		miso_oe_o  = 1'b0;
		override_o = serial_port_enable_bit;
		if (serial_port_enable_bit && master_select_bit) begin
			mosi_oe_o = dir_mosi_i;
			sck_oe_o  = dir_sck_i;
		end else if (serial_port_enable_bit) begin
			miso_oe_o = dir_miso_i && !ss_n_i;
		end
	end

	assign mosi_o    = lsb_first ? sh_q[0] : sh_q[7];
	assign sck_o     = sck_q;
	assign miso_o    = slv_miso;
	assign ctrl_o    = serial_port_control_q;
	assign rx_data_o = rx_q;
	assign flag_o    = transfer_done_flag_q;
	assign wcol_o    = wcol_q;
	assign busy_o    = busy;
	assign irq_o     = transfer_done_flag_q && transfer_irq_enable;

	// rising serial clock edges within one master byte, checking only
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			edge_cnt_q <= 4'h0;
		end else if (state_q == MST_IDLE && wr_ok) begin
			edge_cnt_q <= 4'h0;
		end else if (mst_rise) begin
			edge_cnt_q <= edge_cnt_q + 4'h1;
		end
	end

	property p_eight_edges;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		mst_done |-> edge_cnt_q == `SPIMSB_BYTE_BITS;
	endproperty
	a_eight_edges: assert property (p_eight_edges)
		else $error("master byte did not carry eight clock edges");

	property p_start;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		(wr_ok && master_select_bit && !mode_fault && !ctrl_wr_i)
		|=> state_q == MST_LEAD && sck_q == 1'b0;
	endproperty
	a_start: assert property (p_start)
		else $error("data write did not start the master");

	property p_done_flag;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		mst_done |=> transfer_done_flag_q && state_q == MST_IDLE && !sck_q;
	endproperty
	a_done_flag: assert property (p_done_flag)
		else $error("byte end did not stop clock and set flag");

	property p_irq;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		irq_o == (transfer_done_flag_q && transfer_irq_enable);
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt request does not follow flag and enable");

	property p_collision;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		wr_col |=> wcol_q && serial_port_data_q == $past(serial_port_data_q);
	endproperty
	a_collision: assert property (p_collision)
		else $error("write during transfer not refused and flagged");

	property p_slave_idle;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		(!master_select_bit && ss_n_i) |-> !miso_oe_o && !link_rst_n;
	endproperty
	a_slave_idle: assert property (p_slave_idle)
		else $error("deselected slave drives miso or shifts");

	property p_disabled;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		$rose(transfer_done_flag_q) |-> $past(serial_port_enable_bit);
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("flag set while port disabled");

	property p_fault;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		mode_fault |=> !master_select_bit && transfer_done_flag_q
		               && state_q == MST_IDLE;
	endproperty
	a_fault: assert property (p_fault)
		else $error("select pulled low did not drop master mode");

	property p_pins;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		!serial_port_enable_bit |-> !mosi_oe_o && !sck_oe_o && !miso_oe_o;
	endproperty
	a_pins: assert property (p_pins)
		else $error("pin drive while port disabled");

endmodule // spimsb_port

// ### src/spimsb_regs.svh
// field positions, reset values and counts of the byte port
`ifndef SPIMSB_REGS_SVH
`define SPIMSB_REGS_SVH

// control byte field positions
`define SPIMSB_CTRL_IE      7
`define SPIMSB_CTRL_EN      6
`define SPIMSB_CTRL_LSB     5
`define SPIMSB_CTRL_MASTER_SELECT_BIT    4
`define SPIMSB_CTRL_DBL     2
`define SPIMSB_CTRL_RATE_HI 1
`define SPIMSB_CTRL_RATE_LO 0

// reset values
`define SPIMSB_CTRL_RST     8'h00
`define SPIMSB_DATA_RST     8'h00

// bit index of the last bit of a byte, and bits per byte
`define SPIMSB_LAST_BIT     3'h7
`define SPIMSB_BYTE_BITS    4'h8

// terminal count of one serial clock half period, in system clocks
`define SPIMSB_HALF_DIV2    8'h00
`define SPIMSB_HALF_DIV4    8'h01
`define SPIMSB_HALF_DIV8    8'h03
`define SPIMSB_HALF_DIV16   8'h07
`define SPIMSB_HALF_DIV32   8'h0f
`define SPIMSB_HALF_DIV64   8'h1f
`define SPIMSB_HALF_DIV128  8'h3f

`endif

// ### src/spimsb_pkg.sv
// types shared by the byte port modules
package spimsb_pkg;

	typedef logic [7:0] spimsb_byte_t;

	typedef enum logic [1:0] {
		MST_IDLE  = 2'b00,
		MST_LEAD  = 2'b01,
		MST_TRAIL = 2'b10
	} spimsb_mst_state_t;

endpackage : spimsb_pkg

// ### src/spimsb_slave.sv
// slave shifter running on the external serial clock
`timescale 1ns/10ps
`include "spimsb_regs.svh"

module spimsb_slave
	import spimsb_pkg::*;
(
	input  wire logic         sck_i,
	input  wire logic         link_rst_n_i,
	input  wire logic         resetn_i,
	input  wire logic         mosi_i,
	input  wire spimsb_byte_t tx_byte_i,
	input  wire logic         lsb_first_i,
	output logic              miso_o,
	output logic              done_tgl_o,
	output spimsb_byte_t      rx_byte_o
);

	logic [2:0]   cnt_q;
	logic [2:0]   oidx_q;
	spimsb_byte_t sh_q;
	spimsb_byte_t sh_d;

	// next receive value, order chosen by software
	always_comb begin
		sh_d = lsb_first_i ? {mosi_i, sh_q[7:1]} : {sh_q[6:0], mosi_i};
	end

	// select high resets the bit counter, so every frame starts aligned
	always_ff @(posedge sck_i or negedge link_rst_n_i) begin
		if (!link_rst_n_i) begin
			cnt_q <= 3'h0;
			sh_q  <= `SPIMSB_DATA_RST;
		end else begin
			cnt_q <= cnt_q + 3'h1;
			sh_q  <= sh_d;
		end
	end

	// completed byte and its event toggle survive the end of the frame
	always_ff @(posedge sck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_byte_o  <= `SPIMSB_DATA_RST;
			done_tgl_o <= 1'b0;
		end else if (link_rst_n_i && cnt_q == `SPIMSB_LAST_BIT) begin
			rx_byte_o  <= sh_d;
			done_tgl_o <= ~done_tgl_o;
		end
	end

	// output index advances on trailing edges, first bit shows before
	always_ff @(negedge sck_i or negedge link_rst_n_i) begin
		if (!link_rst_n_i) begin
			oidx_q <= 3'h0;
		end else begin
			oidx_q <= oidx_q + 3'h1;
		end
	end

	// transmit byte is held still by the system side while a frame runs
	always_comb begin
		miso_o = lsb_first_i ? tx_byte_i[oidx_q]
		                     : tx_byte_i[`SPIMSB_LAST_BIT - oidx_q];
	end

endmodule // spimsb_slave

// ### verif/spimsb_peer.sv
// far side model: a slave for master tests, a master for slave tests
`timescale 1ns/10ps

module spimsb_peer (
	input  wire logic pin_sck_i,
	input  wire logic pin_mosi_i,
	input  wire logic pin_miso_i,
	input  wire logic sel_n_i,
	output logic      sck_o,
	output logic      ss_n_o,
	output logic      mosi_o,
	output logic      miso_o
);
	logic [7:0] s_tx;
	logic [7:0] s_rx;
	logic [7:0] m_rx;
	logic       s_last;

	// idle levels: link clock low, select high
	initial begin
		sck_o = 1'b0;
		ss_n_o = 1'b1;
		mosi_o = 1'b0;
		s_tx = 8'h00;
		s_rx = 8'h00;
		m_rx = 8'h00;
		s_last = 1'b0;
	end

	// released line shows the inverse of the last bit, never a stale match
	assign miso_o = sel_n_i ? ~s_last : s_tx[7];

	// slave side, mode 0: sample on rise
	always @(posedge pin_sck_i) begin
		if (!sel_n_i) s_rx <= {s_rx[6:0], pin_mosi_i};
	end

	// slave side, mode 0: advance on fall
	always @(negedge pin_sck_i) begin
		if (!sel_n_i) begin
			s_last <= s_tx[7];
			s_tx <= {s_tx[6:0], s_tx[7]};
		end
	end

	// master side: one byte per frame, link clock runs only inside it,
	// at a quarter of the system clock since the port oversamples it
	task automatic frame(input logic [7:0] tx);
		ss_n_o = 1'b0;
		#40;
		for (int i = 7; i >= 0; i--) begin
			mosi_o = tx[i];
			#50;
			sck_o = 1'b1;
			m_rx = {m_rx[6:0], pin_miso_i};
			#50;
			sck_o = 1'b0;
		end
		#40;
		ss_n_o = 1'b1;
		mosi_o = ~tx[0];
	endtask
endmodule // spimsb_peer

// ### verif/tb.sv
// self-checking bench of the byte port against the far side model
`timescale 1ns/10ps

module tb
	import spimsb_pkg::*;
;
	typedef struct {
		spimsb_byte_t c;
		spimsb_byte_t t;
		spimsb_byte_t p;
		int           h;
	} spimsb_row_t;

	// control byte, byte sent, byte answered, half period in clocks
	spimsb_row_t rows [8] = '{
		'{8'h50, 8'ha5, 8'h3c, 2}, '{8'hd1, 8'h01, 8'h80, 8},
		'{8'h52, 8'hff, 8'h00, 32}, '{8'h53, 8'h00, 8'hff, 64},
		'{8'h74, 8'h5a, 8'hc3, 1}, '{8'h55, 8'h81, 8'h7e, 4},
		'{8'hf6, 8'h96, 8'h69, 16}, '{8'h57, 8'h0f, 8'hf0, 32}};

	logic         sys_clk_i;
	logic         resetn_i;
	logic         dir_mosi_i;
	logic         dir_miso_i;
	logic         dir_sck_i;
	logic         dir_ss_i;
	logic         ctrl_wr_i;
	logic         data_wr_i;
	logic         flag_clr_i;
	logic         p_sel_n;
	spimsb_byte_t ctrl_wdata_i;
	spimsb_byte_t data_wdata_i;
	spimsb_byte_t ctrl_o;
	spimsb_byte_t rx_data_o;
	logic         mosi_o, mosi_oe_o, sck_o, sck_oe_o, miso_o, miso_oe_o;
	logic         override_o, flag_o, wcol_o, busy_o, irq_o;
	logic         p_sck, p_ss_n, p_mosi, p_miso;
	logic         sck_w, mosi_w, miso_w;
	int           errors = 0;
	int           n_compared = 0;

	// wire levels from the port's enables, else the far side model
	assign sck_w = sck_oe_o ? sck_o : p_sck;
	assign mosi_w = mosi_oe_o ? mosi_o : p_mosi;
	assign miso_w = miso_oe_o ? miso_o : p_miso;

	spimsb_port spimsb_port_inst (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .sck_i(sck_w),
		.mosi_i(mosi_w), .miso_i(miso_w), .ss_n_i(p_ss_n),
		.dir_mosi_i(dir_mosi_i), .dir_miso_i(dir_miso_i),
		.dir_sck_i(dir_sck_i), .dir_ss_i(dir_ss_i),
		.ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i),
		.data_wr_i(data_wr_i), .data_wdata_i(data_wdata_i),
		.flag_clr_i(flag_clr_i), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o),
		.sck_o(sck_o), .sck_oe_o(sck_oe_o), .miso_o(miso_o),
		.miso_oe_o(miso_oe_o), .override_o(override_o), .ctrl_o(ctrl_o),
		.rx_data_o(rx_data_o), .flag_o(flag_o), .wcol_o(wcol_o),
		.busy_o(busy_o), .irq_o(irq_o));

	spimsb_peer spimsb_peer_inst (
		.pin_sck_i(sck_w), .pin_mosi_i(mosi_w), .pin_miso_i(miso_w),
		.sel_n_i(p_sel_n), .sck_o(p_sck), .ss_n_o(p_ss_n),
		.mosi_o(p_mosi), .miso_o(p_miso));

	// 40 MHz system clock
	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic tally_and_finish();
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// one-cycle strobe: 0 control, 1 data, 2 flag clear
	task automatic put(input int w, input spimsb_byte_t b);
		@(negedge sys_clk_i);
		ctrl_wdata_i = b;
		data_wdata_i = b;
		ctrl_wr_i = (w == 0);
		data_wr_i = (w == 1);
		flag_clr_i = (w == 2);
		@(negedge sys_clk_i);
		ctrl_wr_i = 1'b0;
		data_wr_i = 1'b0;
		flag_clr_i = 1'b0;
	endtask

	// bounded wait for the done flag, counting serial clock activity
	task automatic wait_flag(output int hi, output int ri);
		logic prev;
		prev = 1'b0;
		hi = 0;
		ri = 0;
		for (int k = 0; k < 3000 && flag_o !== 1'b1; k++) begin
			@(negedge sys_clk_i);
			if (sck_o === 1'b1) hi++;
			if (sck_o === 1'b1 && prev !== 1'b1) ri++;
			prev = sck_o;
		end
		if (flag_o !== 1'b1) begin
			errors++;
			tally_and_finish();
		end
	endtask

	function automatic spimsb_byte_t rev(input spimsb_byte_t b);
		return {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
	endfunction

	initial begin
		int hi, ri;
		spimsb_byte_t x, y;
		resetn_i = 1'b0;
		{dir_mosi_i, dir_miso_i, dir_sck_i, dir_ss_i} = 4'hf;
		{ctrl_wr_i, data_wr_i, flag_clr_i} = 3'b000;
		ctrl_wdata_i = 8'h00;
		data_wdata_i = 8'h00;
		p_sel_n = 1'b0;
		repeat (12) @(negedge sys_clk_i);
		resetn_i = 1'b1;
		chk({ctrl_o, rx_data_o}, 16'h0000);
		chk(16'({flag_o, wcol_o, busy_o, override_o, sck_o}), 16'h0000);
		// master transfers over every rate code
		foreach (rows[i]) begin
			put(0, rows[i].c);
			chk(16'(ctrl_o), 16'(rows[i].c));
			spimsb_peer_inst.s_tx = rows[i].p;
			x = rows[i].c[5] ? rev(rows[i].t) : rows[i].t;
			y = rows[i].c[5] ? rev(rows[i].p) : rows[i].p;
			put(1, rows[i].t);
			wait_flag(hi, ri);
			chk(16'(ri), 16'h0008);
			chk(16'(hi), 16'(8 * rows[i].h));
			chk(16'({flag_o, sck_o, busy_o, irq_o}), 16'({3'b100, rows[i].c[7]}));
			chk(16'({mosi_oe_o, sck_oe_o, miso_oe_o, override_o}), 16'h000d);
			chk({rx_data_o, spimsb_peer_inst.s_rx}, {y, x});
			put(2, 8'h00);
			chk(16'({flag_o, irq_o}), 16'h0000);
		end
		// second write while shifting collides and is dropped
		put(0, 8'h50);
		put(1, 8'ha5);
		put(1, 8'hc3);
		wait_flag(hi, ri);
		chk(16'(wcol_o), 16'h0001);
		chk(16'(spimsb_peer_inst.s_rx), 16'h00a5);
		put(2, 8'h00);
		chk(16'(wcol_o), 16'h0000);
		// slave mode: idle while unselected, then two frames
		p_sel_n = 1'b1;
		put(0, 8'h40);
		chk(16'({miso_oe_o, mosi_oe_o, sck_oe_o}), 16'h0000);
		put(1, 8'ha5);
		chk(16'(busy_o), 16'h0000);
		spimsb_peer_inst.frame(8'h3c);
		wait_flag(hi, ri);
		chk({rx_data_o, spimsb_peer_inst.m_rx}, 16'h3ca5);
		put(2, 8'h00);
		put(1, 8'h96);
		chk(16'(rx_data_o), 16'h003c);
		spimsb_peer_inst.frame(8'h5a);
		wait_flag(hi, ri);
		chk({rx_data_o, spimsb_peer_inst.m_rx}, 16'h5a96);
		put(2, 8'h00);
		// clock edges with select high must be ignored
		repeat (8) begin
			#50 spimsb_peer_inst.sck_o = 1'b1;
			#50 spimsb_peer_inst.sck_o = 1'b0;
		end
		repeat (8) @(negedge sys_clk_i);
		chk(16'({flag_o, busy_o}), 16'h0000);
		// disabled port neither shifts nor flags
		put(0, 8'h00);
		chk(16'({override_o, mosi_oe_o, sck_oe_o}), 16'h0000);
		put(1, 8'h11);
		repeat (40) @(negedge sys_clk_i);
		chk(16'({busy_o, flag_o, wcol_o}), 16'h0000);
		// select input pulled low while master
		put(0, 8'h50);
		dir_ss_i = 1'b0;
		spimsb_peer_inst.ss_n_o = 1'b0;
		repeat (6) @(negedge sys_clk_i);
		chk({ctrl_o, 7'h00, flag_o}, 16'h4001);
		spimsb_peer_inst.ss_n_o = 1'b1;
		dir_ss_i = 1'b1;
		// reset again in mid-run
		resetn_i = 1'b0;
		@(negedge sys_clk_i);
		chk({ctrl_o, rx_data_o}, 16'h0000);
		chk(16'({flag_o, sck_o, override_o}), 16'h0000);
		resetn_i = 1'b1;
		repeat (4) @(negedge sys_clk_i);
		chk(16'({flag_o, busy_o, override_o, sck_o}), 16'h0000);
		tally_and_finish();
	end
endmodule // tb
